// ### rtl/swr_pkg.sv
// Package for the single-wire identity and check-byte front end.
// Assumes a single clock domain; no software-visible registers.
package swr_pkg;
  localparam int unsigned SWR_ID_BITS = 64;
  localparam int unsigned SWR_TYPE_BITS = 8;
  localparam int unsigned SWR_SER_BITS = 48;
  localparam int unsigned SWR_CRC_BITS = 8;
  localparam int unsigned SWR_BODY_BITS = SWR_TYPE_BITS + SWR_SER_BITS;
  // x^8 + x^5 + x^4 + 1 in reflected form for a right shift
  localparam logic [7:0] SWR_CRC_POLY = 8'h8C;
  localparam logic [7:0] SWR_CRC_INIT = 8'h00;
  localparam logic [7:0] SWR_PROG_IDLE = 8'hFF;
  // Type code value is arbitrary
  localparam logic [7:0] SWR_TYPE_DEF = 8'h5A;
  // Serial value is arbitrary
  localparam logic [47:0] SWR_SER_DEF = 48'h0123_4567_89AB;
  localparam int unsigned SWR_FIFO_DEPTH = 8;
  localparam logic [7:0] SWR_CMD_READ_ROM = 8'h33;
  localparam logic [7:0] SWR_CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] SWR_CMD_SEARCH_ROM = 8'hF0;
  localparam logic [7:0] SWR_CMD_SKIP_ROM = 8'hCC;

  typedef enum logic [1:0] {
    SWR_ST_ROM = 2'b00,
    SWR_ST_LOCK = 2'b01,
    SWR_ST_MEM = 2'b11
  } swr_gate_t;

  // One accumulator step: xor in bit, shift right, fold polynomial
  function automatic logic [7:0] swr_crc_step(input logic [7:0] crc,
                                              input logic bit_in);
    logic fb;
    fb = crc[0] ^ bit_in;
    swr_crc_step = {1'b0, crc[7:1]} ^ (fb ? SWR_CRC_POLY : 8'h00);
  endfunction : swr_crc_step

  // Check byte over type code and serial, lowest bit first
  function automatic logic [7:0] swr_crc_body(input logic [55:0] body);
    logic [7:0] c;
    c = SWR_CRC_INIT;
    for (int i = 0; i < 56; i++) begin
      c = swr_crc_step(c, body[i]);
    end
    swr_crc_body = c;
  endfunction : swr_crc_body
endpackage : swr_pkg

// ### rtl/swr_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module swr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  // Full and empty from the occupancy count
  assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_reg != '0);
  assign rd_data_out = mem_reg[rp_reg];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;

  // Pointer and storage update
  always_comb begin
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (do_wr) begin
      mem_next[wp_reg] = wr_data_in;
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
    end
    if (do_rd) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + AW'(1);
    end
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : swr_fifo

// ### rtl/swr_front.sv
// Identity code, check byte and memory-command gate of a single-wire token.
// Assumes a slot layer outside that turns bus time slots into bit strobes,
// reports bus resets and command bytes, and drives the line from tx bits.
// Notes on behaviour
// RQ1: The device holds a fixed 64-bit identity of type code, serial, check.
// RQ2: The check byte is a CRC with generator x^8 + x^5 + x^4 + 1.
// RQ3: The check accumulator is cleared to zero before any bit enters.
// RQ4: Bits enter one at a time, type code LSB first, then the serial.
// RQ5: Feeding the stored check byte after the body returns zero.
// RQ6: Memory commands are ignored until a ROM command completes.
// RQ7: After reset the master first sends one of the four ROM commands.
// RQ8: After a ROM command the five memory command types are accepted.
// RQ9: Every byte on the bus travels lowest bit first.
// RQ10: Programming may only turn a memory bit from 1 to 0.
// RQ11: A high-voltage indication gates the programming of chosen bits.
// RQ12: The master exchanges commands at logic levels, then pulses high.
// RQ13: ROM commands act only on the identity code.
// RQ14: Each step xors bit with the low bit, shifts right, folds feedback.
`timescale 1ns/100ps
module swr_front
  import swr_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = SWR_TYPE_DEF,
  parameter logic [47:0] SERIAL = SWR_SER_DEF,
  parameter int unsigned FIFO_DEPTH = SWR_FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic bus_reset_in,
  input wire logic rom_cmd_valid_in,
  input wire logic [7:0] rom_cmd_in,
  input wire logic rom_cmd_done_in,
  input wire logic mem_cmd_valid_in,
  output logic mem_cmd_accept_out,
  output logic mem_cmd_ignore_out,
  input wire logic id_start_in,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic rx_bit_valid_in,
  input wire logic rx_bit_in,
  input wire logic rx_clear_in,
  output logic [7:0] rx_crc_out,
  output logic rx_crc_zero_out,
  input wire logic prog_voltage_in,
  input wire logic prog_req_in,
  input wire logic [7:0] prog_old_in,
  input wire logic [7:0] prog_data_in,
  output logic [7:0] prog_value_out,
  output logic prog_strobe_out,
  output logic mem_enabled_out
);
  // Identity: check byte derived from the body at elaboration time
  localparam logic [55:0] ID_BODY = {SERIAL, TYPE_CODE}; // RQ1
  localparam logic [7:0] ID_CRC = swr_crc_body(ID_BODY); // RQ2 RQ4
  localparam logic [63:0] ID_CODE = {ID_CRC, ID_BODY}; // RQ1

  swr_gate_t gate_reg, gate_next;
  logic [7:0] crc_reg, crc_next;
  logic [2:0] id_idx_reg, id_idx_next;
  logic id_busy_reg, id_busy_next;
  logic [7:0] pv_reg, pv_next;
  logic ps_reg, ps_next;
  logic acc_reg, acc_next, ign_reg, ign_next;
  logic fifo_ready;
  logic rom_cmd_ok;
  logic [7:0] id_byte;

  // Only the four ROM commands count; they touch nothing but the identity
  assign rom_cmd_ok = (rom_cmd_in == SWR_CMD_READ_ROM) ||
                      (rom_cmd_in == SWR_CMD_MATCH_ROM) ||
                      (rom_cmd_in == SWR_CMD_SEARCH_ROM) ||
                      (rom_cmd_in == SWR_CMD_SKIP_ROM); // RQ13

  // Gate: bus reset relocks; completed ROM command opens memory access
  // Codes step one bit at a time: locked, pending, then open
  always_comb begin
    gate_next = gate_reg;
    unique case (gate_reg)
      SWR_ST_ROM: begin
        if (rom_cmd_valid_in && rom_cmd_ok) begin
          gate_next = SWR_ST_LOCK;
        end
      end
      SWR_ST_LOCK: begin
        if (rom_cmd_done_in) begin
          gate_next = SWR_ST_MEM; // RQ8
        end
      end
      SWR_ST_MEM: gate_next = SWR_ST_MEM;
      default: gate_next = SWR_ST_ROM;
    endcase
    if (bus_reset_in) begin
      gate_next = SWR_ST_ROM; // RQ6 RQ7
    end
  end

  // Memory command answer: accepted or ignored as a one-cycle pulse
  always_comb begin
    acc_next = mem_cmd_valid_in && (gate_reg == SWR_ST_MEM) &&
               !bus_reset_in; // RQ8
    ign_next = mem_cmd_valid_in && !acc_next; // RQ6
  end

  // Receive accumulator; clear or bus reset wins over a bit in the same cycle
  always_comb begin
    crc_next = crc_reg;
    if (rx_clear_in || bus_reset_in) begin
      crc_next = SWR_CRC_INIT; // RQ3
    end else if (rx_bit_valid_in) begin
      crc_next = swr_crc_step(crc_reg, rx_bit_in); // RQ14 RQ9
    end
  end

  // Identity streamed as eight bytes, type code byte first
  always_comb begin
    id_idx_next = id_idx_reg;
    id_busy_next = id_busy_reg;
    if (bus_reset_in) begin
      id_busy_next = 1'b0;
      id_idx_next = '0;
    end else if (!id_busy_reg && id_start_in) begin
      id_busy_next = 1'b1;
      id_idx_next = '0;
    end else if (id_busy_reg && fifo_ready) begin
      id_idx_next = id_idx_reg + 3'd1;
      if (id_idx_reg == 3'd7) begin
        id_busy_next = 1'b0;
      end
    end
  end

  // Programming only clears bits, and only with the high voltage present
  always_comb begin
    pv_next = pv_reg;
    ps_next = 1'b0;
    if (prog_req_in && prog_voltage_in && (gate_reg == SWR_ST_MEM)) begin
      pv_next = prog_old_in & prog_data_in; // RQ10
      ps_next = 1'b1; // RQ11
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_reg <= SWR_ST_ROM;
      crc_reg <= SWR_CRC_INIT;
      id_idx_reg <= '0;
      id_busy_reg <= 1'b0;
      pv_reg <= SWR_PROG_IDLE;
      ps_reg <= 1'b0;
      acc_reg <= 1'b0;
      ign_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      crc_reg <= crc_next;
      id_idx_reg <= id_idx_next;
      id_busy_reg <= id_busy_next;
      pv_reg <= pv_next;
      ps_reg <= ps_next;
      acc_reg <= acc_next;
      ign_reg <= ign_next;
    end
  end

  // Byte picked by index; byte 0 carries the type code, so the line
  // sees the type code first and the check byte last
  assign id_byte = ID_CODE[{id_idx_reg, 3'b000} +: 8]; // RQ9

  // Buffer lets the slot layer stall without losing identity bytes
  swr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_data_in(id_byte),
    .wr_valid_in(id_busy_reg),
    .wr_ready_out(fifo_ready),
    .rd_data_out(tx_byte_out),
    .rd_valid_out(tx_valid_out),
    .rd_ready_in(tx_ready_in)
  );

  assign rx_crc_out = crc_reg;
  assign rx_crc_zero_out = (crc_reg == 8'h00); // RQ5
  assign prog_value_out = pv_reg;
  assign prog_strobe_out = ps_reg;
  assign mem_cmd_accept_out = acc_reg;
  assign mem_cmd_ignore_out = ign_reg;
  assign mem_enabled_out = (gate_reg == SWR_ST_MEM);

  // Checks on the gate, the accumulator, programming and the stream
  chk_mem_gate_hold: assert property (@(posedge clk_sys_in) // RQ6
    disable iff (!reset_n_in)
    $past(bus_reset_in) |-> !mem_enabled_out)
    else $error("memory open right after bus reset");

  chk_mem_accept_gate: assert property (@(posedge clk_sys_in) // RQ8
    disable iff (!reset_n_in)
    mem_cmd_valid_in && mem_enabled_out && !bus_reset_in
      |=> mem_cmd_accept_out && !mem_cmd_ignore_out)
    else $error("memory command not accepted when open");

  chk_mem_ignore_gate: assert property (@(posedge clk_sys_in) // RQ6
    disable iff (!reset_n_in)
    mem_cmd_valid_in && !mem_enabled_out |=> mem_cmd_ignore_out)
    else $error("memory command not ignored while locked");

  chk_crc_clear: assert property (@(posedge clk_sys_in) // RQ3
    disable iff (!reset_n_in)
    rx_clear_in |=> rx_crc_out == 8'h00)
    else $error("accumulator not cleared");

  chk_crc_step: assert property (@(posedge clk_sys_in) // RQ14
    disable iff (!reset_n_in)
    rx_bit_valid_in && !rx_clear_in && !bus_reset_in |=>
      rx_crc_out == (({1'b0, $past(rx_crc_out[7:1])}) ^
        (($past(rx_crc_out[0]) ^ $past(rx_bit_in)) ? 8'h8C : 8'h00)))
    else $error("accumulator step wrong");

  chk_prog_only_clear: assert property (@(posedge clk_sys_in) // RQ10
    disable iff (!reset_n_in)
    prog_strobe_out |-> (prog_value_out & ~$past(prog_old_in)) == 8'h00)
    else $error("programming set a bit");

  chk_prog_needs_hv: assert property (@(posedge clk_sys_in) // RQ11
    disable iff (!reset_n_in)
    prog_strobe_out |-> $past(prog_voltage_in) && $past(prog_req_in))
    else $error("programming without high voltage");

  // Residue of all 64 identity bits; zero means the check byte cancels
  // the body, which is what a receiver relies on to trust the code
  function automatic logic [7:0] id_residue(input logic [63:0] code);
    logic [7:0] c;
    c = SWR_CRC_INIT;
    for (int i = 0; i < 64; i++) begin
      c = swr_crc_step(c, code[i]);
    end
    id_residue = c;
  endfunction : id_residue

  chk_id_check_byte: assert property (@(posedge clk_sys_in) // RQ5
    disable iff (!reset_n_in)
    id_residue(ID_CODE) == 8'h00)
    else $error("identity check byte mismatch");

  chk_rom_open_needs: assert property (@(posedge clk_sys_in) // RQ7
    disable iff (!reset_n_in)
    $rose(mem_enabled_out) |-> $past(rom_cmd_done_in))
    else $error("memory opened without ROM command");

  // Gate states move only on the expected events
  chk_rom_code_filter: assert property (@(posedge clk_sys_in) // RQ13
    disable iff (!reset_n_in)
    (gate_reg == SWR_ST_ROM) && !(rom_cmd_valid_in && rom_cmd_ok)
      |=> gate_reg == SWR_ST_ROM)
    else $error("gate left idle without a ROM command");

  chk_lock_waits_done: assert property (@(posedge clk_sys_in) // RQ6
    disable iff (!reset_n_in)
    (gate_reg == SWR_ST_LOCK) && !rom_cmd_done_in |=> !mem_enabled_out)
    else $error("memory opened before sequence done");

  chk_mem_answer_cause: assert property (@(posedge clk_sys_in) // RQ8
    disable iff (!reset_n_in)
    mem_cmd_accept_out || mem_cmd_ignore_out |-> $past(mem_cmd_valid_in))
    else $error("memory answer without a command");

  // Programming refused unless voltage, request and open gate meet
  chk_prog_locked: assert property (@(posedge clk_sys_in) // RQ6
    disable iff (!reset_n_in)
    prog_req_in && !mem_enabled_out |=> !prog_strobe_out)
    else $error("programming while memory locked");

  chk_prog_no_hv: assert property (@(posedge clk_sys_in) // RQ11
    disable iff (!reset_n_in)
    prog_req_in && !prog_voltage_in |=> !prog_strobe_out)
    else $error("programming without voltage present");

  chk_prog_value_and: assert property (@(posedge clk_sys_in) // RQ10
    disable iff (!reset_n_in)
    prog_req_in && prog_voltage_in && mem_enabled_out |=> prog_strobe_out &&
      prog_value_out == ($past(prog_old_in) & $past(prog_data_in)))
    else $error("programmed value wrong");

  chk_bus_reset_crc: assert property (@(posedge clk_sys_in) // RQ3
    disable iff (!reset_n_in)
    bus_reset_in |=> rx_crc_out == 8'h00)
    else $error("accumulator not cleared by bus reset");

  chk_crc_hold: assert property (@(posedge clk_sys_in) // RQ14
    disable iff (!reset_n_in)
    !rx_bit_valid_in && !rx_clear_in && !bus_reset_in |=> $stable(rx_crc_out))
    else $error("accumulator moved without a bit");

  // Identity stream walks bytes 0 to 7 and then stops
  chk_id_start_idle: assert property (@(posedge clk_sys_in) // RQ1
    disable iff (!reset_n_in)
    !id_busy_reg && id_start_in && !bus_reset_in
      |=> id_busy_reg && id_idx_reg == 3'd0)
    else $error("identity stream did not start at byte 0");

  chk_id_head_type: assert property (@(posedge clk_sys_in) // RQ1
    disable iff (!reset_n_in)
    id_busy_reg && id_idx_reg == 3'd0 |-> id_byte == TYPE_CODE)
    else $error("identity stream does not open with type code");

  chk_id_index_step: assert property (@(posedge clk_sys_in) // RQ9
    disable iff (!reset_n_in)
    id_busy_reg && fifo_ready && !bus_reset_in
      |=> id_idx_reg == $past(id_idx_reg) + 3'd1)
    else $error("identity byte index skipped");

  chk_id_stop_last: assert property (@(posedge clk_sys_in) // RQ1
    disable iff (!reset_n_in)
    id_busy_reg && fifo_ready && id_idx_reg == 3'd7 |=> !id_busy_reg)
    else $error("identity stream ran past its last byte");
endmodule : swr_front

// ### dv/swr_master_model.sv
// Bus master model: takes identity bytes off the tx side and splits
// them into line bits. Assumes one clock and an async low reset.
`timescale 1ns/100ps
module swr_master_model (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic stall_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic line_bits[$];
  // Ready moves only after an edge; a stall keeps bytes in the buffer
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      if (tx_valid_in && tx_ready_out) begin
        for (int i = 0; i < 8; i++) begin
          line_bits.push_back(tx_byte_in[i]);
        end
      end
      tx_ready_out <= !stall_in;
    end
  end
endmodule : swr_master_model

// ### dv/tb.sv
// Self-checking bench for identity, check byte and command gate.
// Assumes the master model is compiled before this file.
`timescale 1ns/100ps
module tb;
  import swr_pkg::*;
  localparam logic [7:0] TC = 8'h3C; // Arbitrary type code
  localparam logic [47:0] SN = 48'h0A1B_2C3D_4E5F; // Arbitrary serial
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, bus_reset_in = 1'b0;
  logic rom_cmd_valid_in = 1'b0, rom_cmd_done_in = 1'b0;
  logic mem_cmd_valid_in = 1'b0, id_start_in = 1'b0, tx_ready_in;
  logic rx_bit_valid_in = 1'b0, rx_bit_in = 1'b0, rx_clear_in = 1'b0;
  logic prog_voltage_in = 1'b0, prog_req_in = 1'b0, stall = 1'b1;
  logic [7:0] rom_cmd_in = 8'h00, prog_old_in = 8'h00;
  logic [7:0] prog_data_in = 8'h00, tx_byte_out, rx_crc_out;
  logic [7:0] prog_value_out;
  logic mem_cmd_accept_out, mem_cmd_ignore_out, tx_valid_out;
  logic rx_crc_zero_out, prog_strobe_out, mem_enabled_out;
  logic [31:0] seed = 32'h45BA;
  logic [63:0] id;
  logic [55:0] body;
  logic [7:0] code [4] = '{8'h33, 8'h55, 8'hF0, 8'hCC};
  int mcrc, errors = 0, compares = 0, n;

  always #20 clk_sys_in = ~clk_sys_in;

  swr_front #(.TYPE_CODE(TC), .SERIAL(SN), .FIFO_DEPTH(8)) dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .bus_reset_in(bus_reset_in), .rom_cmd_valid_in(rom_cmd_valid_in),
    .rom_cmd_in(rom_cmd_in), .rom_cmd_done_in(rom_cmd_done_in),
    .mem_cmd_valid_in(mem_cmd_valid_in),
    .mem_cmd_accept_out(mem_cmd_accept_out),
    .mem_cmd_ignore_out(mem_cmd_ignore_out), .id_start_in(id_start_in),
    .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .rx_bit_valid_in(rx_bit_valid_in),
    .rx_bit_in(rx_bit_in), .rx_clear_in(rx_clear_in),
    .rx_crc_out(rx_crc_out), .rx_crc_zero_out(rx_crc_zero_out),
    .prog_voltage_in(prog_voltage_in), .prog_req_in(prog_req_in),
    .prog_old_in(prog_old_in), .prog_data_in(prog_data_in),
    .prog_value_out(prog_value_out), .prog_strobe_out(prog_strobe_out),
    .mem_enabled_out(mem_enabled_out));
  swr_master_model master (.clk_sys_in, .reset_n_in, .stall_in(stall),
    .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in));

  // Reference accumulator kept in plain integers
  function automatic int m_crc(int c, int b);
    m_crc = (c >> 1) ^ ((((c ^ b) & 1) != 0) ? 32'h8C : 32'h0);
  endfunction : m_crc

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    xs = seed;
  endfunction : xs

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t mismatch got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge clk_sys_in);
  endtask : tick

  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic mem_try(input logic open);
    tick();
    mem_cmd_valid_in <= 1'b1;
    tick();
    mem_cmd_valid_in <= 1'b0;
    #1;
    check(mem_cmd_accept_out, open);
    check(mem_cmd_ignore_out, !open);
  endtask : mem_try

  // Master sends a ROM command, then reports the sequence complete
  task automatic rom_seq(input logic [7:0] c, input logic open);
    tick();
    rom_cmd_valid_in <= 1'b1;
    rom_cmd_in <= c;
    tick();
    rom_cmd_valid_in <= 1'b0;
    rom_cmd_done_in <= 1'b1;
    tick();
    rom_cmd_done_in <= 1'b0;
    #1;
    check(mem_enabled_out, open);
  endtask : rom_seq

  task automatic bus_rst();
    tick();
    bus_reset_in <= 1'b1;
    tick();
    bus_reset_in <= 1'b0;
    #1;
    check(mem_enabled_out, 1'b0);
  endtask : bus_rst

  task automatic prog(input logic hv, input logic open);
    logic [7:0] o, d;
    o = 8'(xs());
    d = 8'(xs());
    tick();
    prog_old_in <= o;
    prog_data_in <= d;
    prog_voltage_in <= hv;
    prog_req_in <= 1'b1;
    tick();
    prog_req_in <= 1'b0;
    prog_voltage_in <= 1'b0;
    #1;
    check(prog_strobe_out, hv & open);
    if (hv & open) check(prog_value_out, o & d);
  endtask : prog

  task automatic feed(input logic b);
    tick();
    rx_bit_valid_in <= 1'b1;
    rx_bit_in <= b;
    tick();
    rx_bit_valid_in <= 1'b0;
    #1;
    mcrc = m_crc(mcrc, int'(b));
    check(rx_crc_out, mcrc[7:0]);
  endtask : feed

  initial begin
    repeat (10) tick();
    reset_n_in <= 1'b1;
    #1;
    check({mem_enabled_out, tx_valid_out, rx_crc_out}, 10'h0);
    check(prog_value_out, 8'hFF);
    mem_try(1'b0);
    prog(1'b1, 1'b0);
    rom_seq(8'h00, 1'b0);
    for (int k = 0; k < 4; k++) begin
      bus_rst();
      mem_try(1'b0);
      rom_seq(code[k], 1'b1);
      mem_try(1'b1);
    end
    prog(1'b0, 1'b1);
    repeat (4) prog(1'b1, 1'b1);
    // Random body, then its own check bits must empty the accumulator
    tick();
    rx_clear_in <= 1'b1;
    tick();
    rx_clear_in <= 1'b0;
    mcrc = 0;
    #1;
    check(rx_crc_out, 8'h00);
    body = 56'({xs(), xs()});
    for (int i = 0; i < 56; i++) feed(body[i]);
    n = mcrc;
    for (int i = 0; i < 8; i++) feed(n[i]);
    check(rx_crc_zero_out, 1'b1);
    // Expected identity worked out from the parameters
    mcrc = 0;
    for (int i = 0; i < 56; i++) mcrc = m_crc(mcrc, int'({SN, TC} >> i) & 1);
    id = {mcrc[7:0], SN, TC};
    // Stalled master lets the buffer fill before draining at random
    tick();
    id_start_in <= 1'b1;
    tick();
    id_start_in <= 1'b0;
    repeat (12) tick();
    #1;
    check(tx_valid_out, 1'b1);
    n = 0;
    while (master.line_bits.size() < 64 && n < 300) begin
      tick();
      stall <= xs() > 32'h8000_0000;
      n++;
    end
    if (n >= 300) begin
      errors++;
      $display("ERROR %0t identity stream timed out", $time);
    end else begin
      mcrc = 0;
      for (int i = 0; i < 64; i++) begin
        check(master.line_bits[i], id[i]);
        mcrc = m_crc(mcrc, int'(master.line_bits[i]));
      end
      check(mcrc, 0);
    end
    bus_rst();
    mem_try(1'b0);
    wrap_up();
  end
endmodule : tb
